//--- hw/pwcm_compare.sv
// Unsigned relational compare of word or double-word operands.
`timescale 1ns/1ps
`include "pwcm_consts.svh"
module pwcm_compare (
	input wire logic [`PWCM_DWORD_W-1:0] a,
	input wire logic [`PWCM_DWORD_W-1:0] b,
	input wire logic dword,
	input wire pwcm_pkg::pwcm_rel_type rel,
	output logic hold,
	output logic eq,
	output logic lt,
	output logic gt
);
	logic [`PWCM_DWORD_W-1:0] am;
	logic [`PWCM_DWORD_W-1:0] bm;
	always_comb begin
		// Word mode ignores the upper halves.
		am = dword ? a : {`PWCM_ZERO_WORD, a[`PWCM_WORD_W-1:0]};
		bm = dword ? b : {`PWCM_ZERO_WORD, b[`PWCM_WORD_W-1:0]};
		eq = (am == bm);
		lt = (am < bm);
		gt = (am > bm);
		case (rel)
			pwcm_pkg::PWCM_REL_EQ: hold = eq;
			pwcm_pkg::PWCM_REL_NE: hold = !eq;
			pwcm_pkg::PWCM_REL_GT: hold = gt;
			pwcm_pkg::PWCM_REL_LT: hold = lt;
			pwcm_pkg::PWCM_REL_GE: hold = !lt;
			pwcm_pkg::PWCM_REL_LE: hold = !gt;
			default: hold = 1'b0;
		endcase
	end
endmodule

//--- hw/pwcm_convert.sv
// Binary to packed decimal, packed decimal to binary, and bit count.
`timescale 1ns/1ps
`include "pwcm_consts.svh"
module pwcm_convert (
	input wire logic [`PWCM_DWORD_W-1:0] src,
	output logic [`PWCM_WORD_W-1:0] to_dec,
	output logic [`PWCM_WORD_W-1:0] to_bin,
	output logic [`PWCM_WORD_W-1:0] ones_word,
	output logic [`PWCM_WORD_W-1:0] ones_dword
);
	function automatic logic [`PWCM_WORD_W-1:0] count_ones(
		input logic [`PWCM_DWORD_W-1:0] v);
		logic [`PWCM_WORD_W-1:0] n;
		n = `PWCM_ZERO_WORD;
		for (int i = 0; i < `PWCM_DWORD_W; i++) begin
			n = n + {15'h0000, v[i]};
		end
		return n;
	endfunction
	logic [`PWCM_DWORD_W-1:0] sh;
	logic [`PWCM_WORD_W-1:0] acc;
	always_comb begin
		// Double dabble; digits above four are truncated.
		sh = {`PWCM_ZERO_WORD, src[`PWCM_WORD_W-1:0]};
		for (int i = 0; i < `PWCM_WORD_W; i++) begin
			for (int k = 0; k < `PWCM_DIGITS; k++) begin
				if (sh[`PWCM_WORD_W+4*k +: 4] > 4'h4) begin
					sh[`PWCM_WORD_W+4*k +: 4] = sh[`PWCM_WORD_W+4*k +: 4] + 4'h3;
				end
			end
			sh = {sh[`PWCM_DWORD_W-2:0], 1'b0};
		end
		to_dec = sh[`PWCM_DWORD_W-1:`PWCM_WORD_W];
		acc = `PWCM_ZERO_WORD;
		for (int k = `PWCM_DIGITS - 1; k >= 0; k--) begin
			acc = 16'(acc * 16'h000a) + {12'h000, src[4*k +: 4]};
		end
		to_bin = acc;
		ones_word = count_ones({`PWCM_ZERO_WORD, src[`PWCM_WORD_W-1:0]});
		ones_dword = count_ones(src);
	end
endmodule

//--- hw/pwcm_unit.sv
// Ladder word compare and move unit with its register file.
// Contract
// - Relational compares work on 16-bit words or 32-bit double words.
// - Six relations per width; contact high only while relation holds; the code registers it a cycle late and only while RUNG_SEL selects it.
// - Contacts combine in series and parallel into a coil output.
// - Byte memory holds multi-byte values lowest byte first.
// - Registers are 16 bits; double word is low then high register.
// - Binary to decimal converts 16-bit binary into packed decimal.
// - Decimal to binary converts 16-bit packed decimal into binary.
// - Population count counts ones in word or double word source.
// - Move copies a word, double word, or constant to destination.
// - Exchange swaps two registers or register pairs.
// - Block fill writes source into count consecutive registers.
// - Block copy copies count registers preserving order; the code always copies forward, also onto an overlapping higher destination.
// - Flag compare works on 16-bit words or 32-bit values.
// - Zero flag set when operands are equal, else cleared.
// - Less-than flag set when first below second, else cleared.
// - Greater-than flag set when first above second, else cleared.
`timescale 1ns/1ps
`include "pwcm_consts.svh"
module pwcm_unit #(
	parameter int REGS = 256
) (
	input wire logic CLK_SYS,
	input wire logic RST,
	input wire logic START,
	input wire pwcm_pkg::pwcm_op_type OP,
	input wire logic [`PWCM_ADDR_W-1:0] SRC,
	input wire logic [`PWCM_ADDR_W-1:0] DST,
	input wire logic SRC_IS_CONST,
	input wire logic [`PWCM_DWORD_W-1:0] CONST_VAL,
	input wire logic [`PWCM_CNT_W-1:0] COUNT,
	input wire logic [`PWCM_ADDR_W-1:0] CMP_B,
	input wire logic CMP_B_IS_CONST,
	input wire logic CMP_DWORD,
	input wire pwcm_pkg::pwcm_rel_type REL,
	input wire logic [1:0] RUNG_SEL,
	input wire logic [2:0] RUNG_FORM,
	input wire logic BYTE_RD_EN,
	input wire logic [`PWCM_ADDR_W:0] BYTE_ADDR,
	output logic BUSY,
	output logic DONE,
	output logic [2:0] CONTACT,
	output logic COIL,
	output logic EQUAL_ZERO_FLAG,
	output logic LESS_THAN_FLAG,
	output logic GREATER_THAN_FLAG,
	output logic [`PWCM_BYTE_W-1:0] BYTE_DATA
);
	// Indexes are eight bits wide, so the file holds at most 256 registers.
	if (REGS < 2 || REGS > (1 << `PWCM_ADDR_W)) begin
		$error("REGS must lie between 2 and 256.");
	end

	// Register indexes wrap from 255 to 0, whatever the size of the file.
	function automatic logic [`PWCM_ADDR_W-1:0] nxt(
		input logic [`PWCM_ADDR_W-1:0] a);
		return a + 8'h01;
	endfunction

	logic [`PWCM_WORD_W-1:0] mem_q [REGS];
	logic [`PWCM_WORD_W-1:0] mem_d [REGS];
	pwcm_pkg::pwcm_state_type st_q, st_d;
	pwcm_pkg::pwcm_op_type op_q, op_d;
	logic [`PWCM_ADDR_W-1:0] src_q, src_d, dst_q, dst_d;
	logic [`PWCM_CNT_W-1:0] cnt_q, cnt_d;
	logic [`PWCM_DWORD_W-1:0] a_q, a_d, b_q, b_d, cv_q, cv_d;
	logic kc_q, kc_d, busy_q, busy_d, done_q, done_d;
	logic kb_q, kb_d;
	logic [2:0] contact_q, contact_d;
	logic coil_q, coil_d, zf_q, zf_d, lf_q, lf_d, gf_q, gf_d;
	logic [`PWCM_BYTE_W-1:0] byte_q, byte_d;
	logic [`PWCM_DWORD_W-1:0] opa, opb;
	logic hold, c_eq, c_lt, c_gt;
	logic [`PWCM_WORD_W-1:0] to_dec, to_bin, ones_w, ones_d;
	logic [`PWCM_WORD_W-1:0] bw;

	function automatic logic [`PWCM_DWORD_W-1:0] rd_pair(
		input logic [`PWCM_ADDR_W-1:0] a);
		return {mem_q[nxt(a)], mem_q[a]};
	endfunction

	// Live operands for the relational contacts.
	always_comb begin
		opa = rd_pair(SRC);
		opb = CMP_B_IS_CONST ? CONST_VAL : rd_pair(CMP_B);
	end

	pwcm_compare u_pwcm_compare (
		.a(st_q == pwcm_pkg::PWCM_S_EXEC ? a_q : opa),
		.b(st_q == pwcm_pkg::PWCM_S_EXEC ? b_q : opb),
		.dword(st_q == pwcm_pkg::PWCM_S_EXEC ?
			(op_q == pwcm_pkg::PWCM_FLAG_CMP_DWORD) : CMP_DWORD),
		.rel(REL),
		.hold(hold),
		.eq(c_eq),
		.lt(c_lt),
		.gt(c_gt)
	);

	// Conversions and bit counts work on the captured source.
	pwcm_convert u_pwcm_convert (
		.src(a_q),
		.to_dec(to_dec),
		.to_bin(to_bin),
		.ones_word(ones_w),
		.ones_dword(ones_d)
	);

	// Selected contact update and rung combining.
	always_comb begin
		contact_d = contact_q;
		// The comparator serves a flag compare for one cycle; contacts hold.
		if (st_q != pwcm_pkg::PWCM_S_EXEC) begin
			contact_d[RUNG_SEL] = hold;
		end
		case (RUNG_FORM)
			3'h0: coil_d = &contact_q;
			3'h1: coil_d = |contact_q;
			3'h2: coil_d = (contact_q[0] | contact_q[1]) & contact_q[2];
			3'h3: coil_d = (contact_q[0] & contact_q[1]) | contact_q[2];
			default: coil_d = contact_q[0];
		endcase
	end

	// Little-endian byte view of the register file.
	always_comb begin
		byte_d = byte_q;
		bw = mem_q[BYTE_ADDR[`PWCM_ADDR_W:1]];
		if (BYTE_RD_EN) begin
			byte_d = BYTE_ADDR[0] ? bw[15:8] : bw[7:0];
		end
	end

	always_comb begin
		st_d = st_q;
		op_d = op_q;
		src_d = src_q;
		dst_d = dst_q;
		cnt_d = cnt_q;
		a_d = a_q;
		b_d = b_q;
		cv_d = cv_q;
		kc_d = kc_q;
		kb_d = kb_q;
		busy_d = busy_q;
		done_d = 1'b0;
		zf_d = zf_q;
		lf_d = lf_q;
		gf_d = gf_q;
		for (int i = 0; i < REGS; i++) begin
			mem_d[i] = mem_q[i];
		end
		case (st_q)
			pwcm_pkg::PWCM_S_IDLE: begin
				if (START && OP != pwcm_pkg::PWCM_NOP &&
					OP != pwcm_pkg::PWCM_REL_CMP) begin
					op_d = OP;
					src_d = SRC;
					dst_d = DST;
					cnt_d = COUNT;
					cv_d = CONST_VAL;
					kc_d = SRC_IS_CONST;
					kb_d = CMP_B_IS_CONST;
					b_d = CMP_B_IS_CONST ? CONST_VAL : {`PWCM_ZERO_WORD, `PWCM_ZERO_WORD};
					busy_d = 1'b1;
					st_d = pwcm_pkg::PWCM_S_RD_A;
				end
			end
			pwcm_pkg::PWCM_S_RD_A: begin
				a_d = kc_q ? cv_q : rd_pair(src_q);
				if (op_q == pwcm_pkg::PWCM_FLAG_CMP_WORD ||
					op_q == pwcm_pkg::PWCM_FLAG_CMP_DWORD) begin
					// Second operand: captured constant, or the pair at DST.
					if (!kb_q) begin
						b_d = rd_pair(dst_q);
					end
					st_d = pwcm_pkg::PWCM_S_EXEC;
				end else if (op_q == pwcm_pkg::PWCM_BLOCK_FILL ||
					op_q == pwcm_pkg::PWCM_BLOCK_COPY) begin
					st_d = (cnt_q == `PWCM_CNT_W'(0)) ?
						pwcm_pkg::PWCM_S_WR : pwcm_pkg::PWCM_S_BLOCK;
				end else begin
					b_d = rd_pair(dst_q);
					st_d = pwcm_pkg::PWCM_S_WR;
				end
			end
			pwcm_pkg::PWCM_S_EXEC: begin
				zf_d = c_eq;
				lf_d = c_lt;
				gf_d = c_gt;
				st_d = pwcm_pkg::PWCM_S_WR;
			end
			pwcm_pkg::PWCM_S_BLOCK: begin
				// One register a cycle; an overlapping copy runs forward.
				if (op_q == pwcm_pkg::PWCM_BLOCK_FILL) begin
					mem_d[dst_q] = a_q[`PWCM_WORD_W-1:0];
				end else begin
					mem_d[dst_q] = mem_q[src_q];
				end
				src_d = nxt(src_q);
				dst_d = nxt(dst_q);
				cnt_d = cnt_q - `PWCM_CNT_W'(1);
				if (cnt_q == `PWCM_CNT_W'(1)) begin
					st_d = pwcm_pkg::PWCM_S_WR;
				end
			end
			pwcm_pkg::PWCM_S_WR: begin
				// Move, exchange, conversion and count results are written on the edge that raises DONE.
				case (op_q)
					pwcm_pkg::PWCM_MOVE_WORD:
						mem_d[dst_q] = a_q[15:0];
					pwcm_pkg::PWCM_MOVE_DWORD: begin
						mem_d[dst_q] = a_q[15:0];
						mem_d[nxt(dst_q)] = a_q[31:16];
					end
					pwcm_pkg::PWCM_SWAP_WORD: begin
						mem_d[dst_q] = a_q[15:0];
						mem_d[src_q] = b_q[15:0];
					end
					pwcm_pkg::PWCM_SWAP_DWORD: begin
						mem_d[dst_q] = a_q[15:0];
						mem_d[nxt(dst_q)] = a_q[31:16];
						mem_d[src_q] = b_q[15:0];
						mem_d[nxt(src_q)] = b_q[31:16];
					end
					pwcm_pkg::PWCM_BIN_TO_DEC: mem_d[dst_q] = to_dec;
					pwcm_pkg::PWCM_DEC_TO_BIN: mem_d[dst_q] = to_bin;
					pwcm_pkg::PWCM_POPCOUNT_WORD: mem_d[dst_q] = ones_w;
					pwcm_pkg::PWCM_POPCOUNT_DWORD: mem_d[dst_q] = ones_d;
					default: ;
				endcase
				busy_d = 1'b0;
				done_d = 1'b1;
				st_d = pwcm_pkg::PWCM_S_IDLE;
			end
			default: st_d = pwcm_pkg::PWCM_S_IDLE;
		endcase
	end

	// Every register, the register file included, clears on reset.
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			st_q <= pwcm_pkg::PWCM_S_IDLE;
			op_q <= pwcm_pkg::PWCM_NOP;
			src_q <= '0;
			dst_q <= '0;
			cnt_q <= '0;
			a_q <= '0;
			b_q <= '0;
			cv_q <= '0;
			kc_q <= 1'b0;
			kb_q <= 1'b0;
			busy_q <= 1'b0;
			done_q <= 1'b0;
			contact_q <= 3'h0;
			coil_q <= 1'b0;
			zf_q <= 1'b0;
			lf_q <= 1'b0;
			gf_q <= 1'b0;
			byte_q <= 8'h00;
			for (int i = 0; i < REGS; i++) begin
				mem_q[i] <= `PWCM_ZERO_WORD;
			end
		end else begin
			st_q <= st_d;
			op_q <= op_d;
			src_q <= src_d;
			dst_q <= dst_d;
			cnt_q <= cnt_d;
			a_q <= a_d;
			b_q <= b_d;
			cv_q <= cv_d;
			kc_q <= kc_d;
			kb_q <= kb_d;
			busy_q <= busy_d;
			done_q <= done_d;
			contact_q <= contact_d;
			coil_q <= coil_d;
			zf_q <= zf_d;
			lf_q <= lf_d;
			gf_q <= gf_d;
			byte_q <= byte_d;
			for (int i = 0; i < REGS; i++) begin
				mem_q[i] <= mem_d[i];
			end
		end
	end

	always_comb begin
		BUSY = busy_q;
		DONE = done_q;
		CONTACT = contact_q;
		COIL = coil_q;
		EQUAL_ZERO_FLAG = zf_q;
		LESS_THAN_FLAG = lf_q;
		GREATER_THAN_FLAG = gf_q;
		BYTE_DATA = byte_q;
	end
endmodule

//--- shared/pwcm_consts.svh
// Constants of the ladder word compare and move unit.
`ifndef PWCM_CONSTS_SVH
`define PWCM_CONSTS_SVH
`define PWCM_WORD_W 16
`define PWCM_DWORD_W 32
`define PWCM_ADDR_W 8
`define PWCM_CNT_W 8
`define PWCM_MAX_COUNT 8'hfe
`define PWCM_BYTE_W 8
`define PWCM_ZERO_WORD 16'h0000
`define PWCM_DIGIT_W 4
`define PWCM_DIGITS 4
`define PWCM_OP_W 5
`endif

//--- shared/pwcm_pkg.sv
// Types of the ladder word compare and move unit.
package pwcm_pkg;
	typedef enum logic [4:0] {
		PWCM_NOP = 5'h00,
		PWCM_MOVE_WORD = 5'h01,
		PWCM_MOVE_DWORD = 5'h02,
		PWCM_SWAP_WORD = 5'h03,
		PWCM_SWAP_DWORD = 5'h04,
		PWCM_BIN_TO_DEC = 5'h05,
		PWCM_DEC_TO_BIN = 5'h06,
		PWCM_POPCOUNT_WORD = 5'h07,
		PWCM_POPCOUNT_DWORD = 5'h08,
		PWCM_FLAG_CMP_WORD = 5'h09,
		PWCM_FLAG_CMP_DWORD = 5'h0a,
		PWCM_BLOCK_FILL = 5'h0b,
		PWCM_BLOCK_COPY = 5'h0c,
		PWCM_REL_CMP = 5'h0d
	} pwcm_op_type;
	typedef enum logic [2:0] {
		PWCM_REL_EQ = 3'h0,
		PWCM_REL_NE = 3'h1,
		PWCM_REL_GT = 3'h2,
		PWCM_REL_LT = 3'h3,
		PWCM_REL_GE = 3'h4,
		PWCM_REL_LE = 3'h5
	} pwcm_rel_type;
	typedef enum logic [5:0] {
		PWCM_S_IDLE = 6'b000001,
		PWCM_S_RD_A = 6'b000010,
		PWCM_S_RD_B = 6'b000100,
		PWCM_S_EXEC = 6'b001000,
		PWCM_S_WR = 6'b010000,
		PWCM_S_BLOCK = 6'b100000
	} pwcm_state_type;
endpackage

//--- test/pwcm_unit_chk.sv
// Port checker of the ladder word compare and move unit.
`timescale 1ns/1ps
module pwcm_unit_chk (
	input wire logic CLK_SYS,
	input wire logic RST,
	input wire logic START,
	input wire pwcm_pkg::pwcm_op_type OP,
	input wire logic [7:0] COUNT,
	input wire logic [2:0] RUNG_FORM,
	input wire logic BYTE_RD_EN,
	input wire logic BUSY,
	input wire logic DONE,
	input wire logic [2:0] CONTACT,
	input wire logic COIL,
	input wire logic EQUAL_ZERO_FLAG,
	input wire logic LESS_THAN_FLAG,
	input wire logic GREATER_THAN_FLAG,
	input wire logic [7:0] BYTE_DATA
);
	logic go;
	logic [2:0] flags;
	assign go = START && !BUSY;
	assign flags = {EQUAL_ZERO_FLAG, LESS_THAN_FLAG, GREATER_THAN_FLAG};
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (RST);
	a_move_done_time:
	assert property (go && OP == pwcm_pkg::PWCM_MOVE_WORD |-> ##3 DONE)
		else $error("word move finished late");
	a_move_busy_span:
	assert property (go && OP == pwcm_pkg::PWCM_MOVE_DWORD
		|=> BUSY [*2] ##1 (DONE && !BUSY))
		else $error("busy span of double move wrong");
	a_flag_done_time:
	assert property (go && (OP == pwcm_pkg::PWCM_FLAG_CMP_WORD ||
		OP == pwcm_pkg::PWCM_FLAG_CMP_DWORD) |-> ##4 DONE)
		else $error("flag compare finished late");
	a_empty_block_done:
	assert property (go && COUNT == 8'h00 && (OP == pwcm_pkg::PWCM_BLOCK_FILL
		|| OP == pwcm_pkg::PWCM_BLOCK_COPY) |-> ##3 DONE)
		else $error("empty block operation finished late");
	a_done_one_cycle:
	assert property (DONE |=> !DONE)
		else $error("done longer than one cycle");
	a_flags_exclusive:
	assert property ($onehot0(flags))
		else $error("more than one compare flag set");
	a_flags_settle:
	assert property ($changed(flags) |-> BUSY || DONE)
		else $error("flags changed outside an operation");
	a_coil_all_and:
	assert property (RUNG_FORM == 3'h0 |=> COIL == &$past(CONTACT))
		else $error("series rung result wrong");
	a_coil_any_or:
	assert property (RUNG_FORM == 3'h1 |=> COIL == |$past(CONTACT))
		else $error("parallel rung result wrong");
	a_byte_kept:
	assert property (!BYTE_RD_EN |=> $stable(BYTE_DATA))
		else $error("byte data changed without a read");
	c_move: cover property (go && OP == pwcm_pkg::PWCM_MOVE_WORD);
	c_flags: cover property (DONE && flags != 3'h0);
	c_coil: cover property ($rose(COIL));
endmodule
bind pwcm_unit pwcm_unit_chk u_pwcm_unit_chk (.CLK_SYS, .RST, .START, .OP,
	.COUNT, .RUNG_FORM, .BYTE_RD_EN, .BUSY, .DONE, .CONTACT, .COIL,
	.EQUAL_ZERO_FLAG, .LESS_THAN_FLAG, .GREATER_THAN_FLAG, .BYTE_DATA);

//--- test/test_plc_word_compare_move_unit.sv
// Self-checking bench of the ladder word compare and move unit.
`timescale 1ns/1ps
module test_plc_word_compare_move_unit;
	logic clk_sys = 1'h0;
	logic rst = 1'h1;
	logic start = 1'h0;
	logic src_is_const = 1'h0;
	logic cmp_b_is_const = 1'h0;
	logic cmp_dword = 1'h0;
	logic byte_rd_en = 1'h0;
	logic req = 1'h0;
	logic req_q = 1'h0;
	pwcm_pkg::pwcm_op_type op = pwcm_pkg::PWCM_NOP;
	pwcm_pkg::pwcm_rel_type rel = pwcm_pkg::PWCM_REL_EQ;
	logic [7:0] src = 8'h00;
	logic [7:0] dst = 8'h00;
	logic [7:0] count = 8'h00;
	logic [7:0] cmp_b = 8'h00;
	logic [31:0] const_val = 32'h0;
	logic [1:0] rung_sel = 2'h0;
	logic [2:0] rung_form = 3'h0;
	logic [8:0] byte_addr = 9'h000;
	logic busy, done, coil, eq_f, lt_f, gt_f;
	logic [2:0] contact;
	logic [7:0] byte_data;
	logic [9:0] exp_q[$];
	logic [31:0] rnd [5];
	logic [31:0] av [3] = '{32'h00018000, 32'h00008000, 32'h00030001};
	logic [31:0] bv [3] = '{32'h00028000, 32'h00000001, 32'h00020002};
	logic [4:0] form_exp = 5'h12;
	int mismatches = 0;
	int n_checks = 0;
	int seed = 24;
	always #5 clk_sys = ~clk_sys;
	pwcm_unit u_pwcm_unit (.CLK_SYS(clk_sys), .RST(rst), .START(start),
		.OP(op), .SRC(src), .DST(dst), .SRC_IS_CONST(src_is_const),
		.CONST_VAL(const_val), .COUNT(count), .CMP_B(cmp_b),
		.CMP_B_IS_CONST(cmp_b_is_const), .CMP_DWORD(cmp_dword), .REL(rel),
		.RUNG_SEL(rung_sel), .RUNG_FORM(rung_form), .BYTE_RD_EN(byte_rd_en),
		.BYTE_ADDR(byte_addr), .BUSY(busy), .DONE(done), .CONTACT(contact),
		.COIL(coil), .EQUAL_ZERO_FLAG(eq_f), .LESS_THAN_FLAG(lt_f),
		.GREATER_THAN_FLAG(gt_f), .BYTE_DATA(byte_data));
	function automatic logic rl(input logic [31:0] a, input logic [31:0] b,
		input logic dw, input logic [2:0] r);
		if (!dw) begin
			a[31:16] = 16'h0000;
			b[31:16] = 16'h0000;
		end
		case (r)
			3'h0: return a == b;
			3'h1: return a != b;
			3'h2: return a > b;
			3'h3: return a < b;
			3'h4: return a >= b;
			default: return a <= b;
		endcase
	endfunction
	task test_done;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task tick;
		@(posedge clk_sys);
		#1;
	endtask
	task automatic run(input pwcm_pkg::pwcm_op_type o, input logic [7:0] s,
		input logic [7:0] d, input logic [7:0] n, input logic c,
		input logic [31:0] v);
		int i;
		op = o;
		src = s;
		dst = d;
		count = n;
		src_is_const = c;
		const_val = v;
		start = 1'h1;
		tick;
		start = 1'h0;
		op = pwcm_pkg::PWCM_NOP;
		for (i = 0; i < 600 && done !== 1'h1; i++) begin
			tick;
		end
		if (i == 600) begin
			mismatches++;
			$display("mismatch %0t done %h exp %h", $time, done, 1'h1);
		end
	endtask
	// Each check holds its request for one cycle, then idles one cycle.
	task chk(input logic [1:0] k, input logic [7:0] e, input logic [8:0] a);
		exp_q.push_back({k, e});
		byte_addr = a;
		byte_rd_en = (k == 2'h0);
		req = 1'h1;
		tick;
		req = 1'h0;
		byte_rd_en = 1'h0;
		tick;
	endtask
	task chkw(input logic [7:0] r, input logic [15:0] e);
		chk(2'h0, e[7:0], {r, 1'h0});
		chk(2'h0, e[15:8], {r, 1'h1});
	endtask
	always @(posedge clk_sys) begin
		logic [9:0] e;
		logic [7:0] got;
		req_q <= req;
		if (req_q) begin
			e = exp_q.pop_front();
			case (e[9:8])
				2'h0: got = byte_data;
				2'h1: got = {5'h00, eq_f, lt_f, gt_f};
				2'h2: got = {7'h00, contact[0]};
				default: got = {7'h00, coil};
			endcase
			n_checks++;
			if (got !== e[7:0]) begin
				mismatches++;
				$display("mismatch %0t got %h exp %h", $time, got, e[7:0]);
			end
		end
	end
	initial begin
		#200000;
		mismatches++;
		test_done;
	end
	initial begin
		int i;
		int j;
		int k;
		repeat (10) @(posedge clk_sys);
		#1;
		rst = 1'h0;
		run(pwcm_pkg::PWCM_MOVE_DWORD, 8'h00, 8'h10, 8'h00, 1'h1, 32'h12345678);
		run(pwcm_pkg::PWCM_MOVE_WORD, 8'h00, 8'h00, 8'h00, 1'h1, 32'hffff1234);
		for (i = 0; i < 5; i++) begin
			rnd[i] = $random(seed);
			run(pwcm_pkg::PWCM_MOVE_WORD, 8'h00, 8'h60 + i[7:0], 8'h00, 1'h1,
				rnd[i]);
		end
		chkw(8'h10, 16'h5678);
		chkw(8'h11, 16'h1234);
		chkw(8'h00, 16'h1234);
		run(pwcm_pkg::PWCM_BIN_TO_DEC, 8'h00, 8'h02, 8'h00, 1'h0, 32'h0);
		run(pwcm_pkg::PWCM_DEC_TO_BIN, 8'h02, 8'h03, 8'h00, 1'h0, 32'h0);
		run(pwcm_pkg::PWCM_POPCOUNT_WORD, 8'h00, 8'h04, 8'h00, 1'h0, 32'h0);
		run(pwcm_pkg::PWCM_POPCOUNT_DWORD, 8'h10, 8'h05, 8'h00, 1'h0, 32'h0);
		chkw(8'h02, 16'h4660);
		chkw(8'h03, 16'h1234);
		chkw(8'h04, 16'h0005);
		chkw(8'h05, 16'h000d);
		run(pwcm_pkg::PWCM_MOVE_WORD, 8'h10, 8'h20, 8'h00, 1'h0, 32'h0);
		run(pwcm_pkg::PWCM_SWAP_WORD, 8'h00, 8'h02, 8'h00, 1'h0, 32'h0);
		run(pwcm_pkg::PWCM_SWAP_DWORD, 8'h10, 8'h20, 8'h00, 1'h0, 32'h0);
		chkw(8'h00, 16'h4660);
		chkw(8'h02, 16'h1234);
		chkw(8'h11, 16'h0000);
		chkw(8'h20, 16'h5678);
		chkw(8'h21, 16'h1234);
		run(pwcm_pkg::PWCM_BLOCK_FILL, 8'h00, 8'h30, 8'h06, 1'h0, 32'h0);
		run(pwcm_pkg::PWCM_BLOCK_FILL, 8'h00, 8'h40, 8'h00, 1'h0, 32'h0);
		run(pwcm_pkg::PWCM_BLOCK_COPY, 8'h60, 8'h70, 8'h05, 1'h0, 32'h0);
		run(pwcm_pkg::PWCM_BLOCK_COPY, 8'h60, 8'h78, 8'h00, 1'h0, 32'h0);
		for (i = 0; i < 7; i++) begin
			chkw(8'h30 + i[7:0], (i < 6) ? 16'h4660 : 16'h0000);
		end
		for (i = 0; i < 6; i++) begin
			chkw(8'h70 + i[7:0], (i < 5) ? rnd[i][15:0] : 16'h0000);
		end
		chkw(8'h40, 16'h0000);
		chkw(8'h78, 16'h0000);
		cmp_b_is_const = 1'h1;
		for (i = 0; i < 3; i++) begin
			run(pwcm_pkg::PWCM_MOVE_DWORD, 8'h00, 8'h80, 8'h00, 1'h1, av[i]);
			for (j = 0; j < 2; j++) begin
				run(j ? pwcm_pkg::PWCM_FLAG_CMP_DWORD : pwcm_pkg::PWCM_FLAG_CMP_WORD,
					8'h80, 8'h00, 8'h00, 1'h0, bv[i]);
				chk(2'h1, {5'h00, rl(av[i], bv[i], j[0], 3'h0),
					rl(av[i], bv[i], j[0], 3'h3),
					rl(av[i], bv[i], j[0], 3'h2)}, 9'h000);
				cmp_dword = j[0];
				for (k = 0; k < 6; k++) begin
					rel = pwcm_pkg::pwcm_rel_type'(k[2:0]);
					chk(2'h2, {7'h00, rl(av[i], bv[i], j[0], k[2:0])}, 9'h000);
				end
			end
		end
		cmp_b_is_const = 1'h0;
		cmp_b = 8'h82;
		run(pwcm_pkg::PWCM_MOVE_DWORD, 8'h00, 8'h82, 8'h00, 1'h1, bv[0]);
		for (j = 0; j < 2; j++) begin
			run(j ? pwcm_pkg::PWCM_FLAG_CMP_DWORD : pwcm_pkg::PWCM_FLAG_CMP_WORD,
				8'h80, 8'h82, 8'h00, 1'h0, 32'h0);
			chk(2'h1, {5'h00, rl(av[2], bv[0], j[0], 3'h0),
				rl(av[2], bv[0], j[0], 3'h3),
				rl(av[2], bv[0], j[0], 3'h2)}, 9'h000);
			cmp_dword = j[0];
			rel = pwcm_pkg::PWCM_REL_GT;
			chk(2'h2, {7'h00, rl(av[2], bv[0], j[0], 3'h2)}, 9'h000);
		end
		rel = pwcm_pkg::PWCM_REL_LT;
		rung_sel = 2'h1;
		tick;
		rung_sel = 2'h2;
		tick;
		rel = pwcm_pkg::PWCM_REL_GT;
		rung_sel = 2'h0;
		tick;
		for (i = 0; i < 5; i++) begin
			rung_form = i[2:0];
			chk(2'h3, {7'h00, form_exp[i]}, 9'h000);
		end
		// A reset in the middle of a block fill clears flags and registers.
		op = pwcm_pkg::PWCM_BLOCK_FILL;
		src = 8'h00;
		dst = 8'h90;
		count = 8'h08;
		src_is_const = 1'h0;
		start = 1'h1;
		tick;
		start = 1'h0;
		op = pwcm_pkg::PWCM_NOP;
		repeat (3) tick;
		rst = 1'h1;
		tick;
		rst = 1'h0;
		chk(2'h1, 8'h00, 9'h000);
		chkw(8'h90, 16'h0000);
		test_done;
	end
endmodule
